/* hw/adc_rate_consts.svh */
// Constant widths, divisors, ratios, shifts, clipping codes, reset values and timing counts of the rate and code control.
`ifndef ADC_RATE_CONSTS_SVH
`define ADC_RATE_CONSTS_SVH

// Number of converter channels sharing the master clock.
`define NUM_CHANNELS      4
`define CODE_WIDTH        24
`define FIFO_DEPTH        16

// Master clock period in ns and the lowest supported master clock in kHz.
`define CLK_PERIOD_NS     10
`define CLK_MIN_KHZ       100

// Master clocks per modulator tick.
`define DIV_BY_4          6'd4
`define DIV_BY_8          6'd8
`define DIV_BY_40         6'd40

// Modulator ticks per output word.
`define OSR_NORMAL        8'd64
`define OSR_HIRES         8'd128

// Left shift that maps the bit balance onto the full 24-bit scale.
`define SHIFT_NORMAL      5'd17
`define SHIFT_HIRES       5'd16

// Output periods until a step has settled.
`define SETTLE_NORMAL     7'd76
`define SETTLE_HIRES      7'd78

// Clipping codes and reset values.
`define CODE_POS_FULL     24'h7FFFFF
`define CODE_NEG_FULL     24'h800000
`define CODE_RESET        24'h000000
`define MODE_RESET        2'b00

`endif

/* hw/adc_rate_pkg.sv */
// Types shared by the rate and code control, its checks, the host model and the testbench.
package adc_rate_pkg;

	typedef enum logic [1:0] {
		MODE_HIGH_SPEED = 2'b00,
		MODE_HIGH_RES   = 2'b01,
		MODE_LOW_POWER  = 2'b10,
		MODE_LOW_SPEED  = 2'b11
	} op_mode_type;

	typedef enum logic [0:0] {
		ST_SETTLING = 1'b0,
		ST_RUNNING  = 1'b1
	} run_state_type;

	typedef struct packed {
		logic [5:0] div;
		logic [7:0] osr;
		logic [4:0] shift;
		logic [6:0] settle;
	} rate_cfg_type;

	typedef struct packed {
		logic [3:0][23:0] code;
	} sample_word_type;

endpackage

/* hw/sample_fifo.sv */
// Synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module sample_fifo #(
	parameter int WIDTH = 96,
	parameter int DEPTH = 16
) (
	input  wire logic             clk_sys_i,
	input  wire logic             srst_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic [WIDTH-1:0]      out_data_o
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wr_ptr;
	logic [PW-1:0]    rd_ptr;
	logic [PW:0]      count;
	logic             do_push;
	logic             do_pop;

	assign in_ready_o  = (count != DEPTH[PW:0]);
	assign out_valid_o = (count != '0);
	assign do_push     = in_valid_i && in_ready_o;
	assign do_pop      = out_valid_o && out_ready_i;
	assign out_data_o  = mem[rd_ptr];

	always_ff @(posedge clk_sys_i) begin
		if (do_push) begin
			mem[wr_ptr] <= in_data_i;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (do_push) begin
				wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			end
			if (do_pop) begin
				rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			end
			if (do_push && !do_pop) begin
				count <= count + 1'b1;
			end else if (do_pop && !do_push) begin
				count <= count - 1'b1;
			end
		end
	end

endmodule // sample_fifo

/* hw/adc_rate_filter_and_code_control.sv */
// Mode decode, modulator and word rate generation, decimation and code clipping for all channels.
`timescale 1ns/1ps
`include "adc_rate_consts.svh"

// Function
// - High-speed, low-power and low-speed decimate by 64 with one filter setup.
// - High-resolution decimates by 128.
// - Modulator tick divides the master clock by 4, 8 or 40 per mode and ratio.
// - One output word per 256, 512 or 2560 master clocks per mode and ratio.
// - Word rate follows the master clock; clocks down to 100 kHz work.
// - All channels run from one master clock in lockstep.
// - Filter has constant group delay, independent of signal frequency.
// - Results settle after 76 periods, or 78 in high-resolution.
// - Each result is a 24-bit twos complement word.
// - Results clip at 7FFFFF and 800000 beyond full scale.
// - One positive step is 000001, zero is 000000, one negative step all ones; the code steps by 040000 per modulator bit, 020000 in high-resolution.
// - Mode pins are sampled continuously; a change needs no reset.
// - Data ready indication stays high after a mode change until results settle.
module adc_rate_filter_and_code_control
	import adc_rate_pkg::*;
(
	input  wire logic                         clk_sys_i,
	input  wire logic                         srst_i,
	input  wire logic [1:0]                   mode_sel_i,
	input  wire logic                         clock_ratio_select_i,
	input  wire logic [`NUM_CHANNELS-1:0]     mod_bit_i,
	output logic                              modulator_rate_o,
	output logic                              data_ready_indication_o,
	output logic                              overrun_o,
	output logic                              sample_valid_o,
	input  wire logic                         sample_ready_i,
	output sample_word_type                   sample_data_o
);

	op_mode_type     mode;
	logic            ratio_sel;
	logic            cfg_change;
	rate_cfg_type    cfg;
	run_state_type   state;
	logic [5:0]      div_cnt;
	logic [7:0]      osr_cnt;
	logic [6:0]      settle_cnt;
	logic            mod_tick;
	logic            frame_end;
	logic [7:0]      ones [`NUM_CHANNELS];
	sample_word_type word;
	logic            word_valid;
	logic            fifo_ready;

	// Decodes the operating selection and ratio select into divider, ratio and settling.
	function automatic rate_cfg_type decode_cfg(input op_mode_type m, input logic r);
		rate_cfg_type c;
		c.osr    = `OSR_NORMAL;
		c.shift  = `SHIFT_NORMAL;
		c.settle = `SETTLE_NORMAL;
		c.div    = `DIV_BY_4;
		unique case (m)
			MODE_HIGH_SPEED: begin
				c.div = `DIV_BY_4;
			end
			MODE_HIGH_RES: begin
				c.div    = `DIV_BY_4;
				c.osr    = `OSR_HIRES;
				c.shift  = `SHIFT_HIRES;
				c.settle = `SETTLE_HIRES;
			end
			MODE_LOW_POWER: begin
				c.div = r ? `DIV_BY_8 : `DIV_BY_4;
			end
			MODE_LOW_SPEED: begin
				c.div = r ? `DIV_BY_40 : `DIV_BY_8;
			end
		endcase
		return c;
	endfunction

	// Maps the balance of ones against zeros onto the code range and clips it.
	function automatic logic [23:0] clip_code(input logic [7:0] n, input rate_cfg_type c);
		logic signed [9:0]  diff;
		logic signed [31:0] scaled;
		diff   = $signed({1'b0, n, 1'b0}) - $signed({2'b00, c.osr});
		scaled = 32'(diff) <<< c.shift;
		if (scaled > $signed({8'h00, `CODE_POS_FULL})) begin
			return `CODE_POS_FULL;
		end else if (scaled < $signed({8'hFF, `CODE_NEG_FULL})) begin
			return `CODE_NEG_FULL;
		end
		return scaled[23:0];
	endfunction

	// The pins are compared on every clock, so a new selection is picked up in operation.
	assign cfg_change = (mode_sel_i != mode) || (clock_ratio_select_i != ratio_sel);
	assign cfg        = decode_cfg(mode, ratio_sel);

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			mode      <= op_mode_type'(`MODE_RESET);
			ratio_sel <= 1'b0;
		end else begin
			mode      <= op_mode_type'(mode_sel_i);
			ratio_sel <= clock_ratio_select_i;
		end
	end

	// The divider counts master clocks only, so every rate scales with the clock itself,
	// down to the slowest supported one.
	assign mod_tick  = (div_cnt == cfg.div - 6'd1);
	assign frame_end = mod_tick && (osr_cnt == cfg.osr - 8'd1);

	always_ff @(posedge clk_sys_i) begin
		if (srst_i || cfg_change) begin
			div_cnt <= 6'h00;
		end else if (mod_tick) begin
			div_cnt <= 6'h00;
		end else begin
			div_cnt <= div_cnt + 6'd1;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i || cfg_change) begin
			osr_cnt <= 8'h00;
		end else if (frame_end) begin
			osr_cnt <= 8'h00;
		end else if (mod_tick) begin
			osr_cnt <= osr_cnt + 8'd1;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			modulator_rate_o <= 1'b0;
		end else begin
			modulator_rate_o <= mod_tick && !cfg_change;
		end
	end

	// Every channel shares one tick and one frame boundary, which keeps them in lockstep.
	// The equal-weight window is symmetric, so its delay does not depend on frequency.
	always_ff @(posedge clk_sys_i) begin
		for (int ch = 0; ch < `NUM_CHANNELS; ch++) begin
			if (srst_i || cfg_change) begin
				ones[ch] <= 8'h00;
			end else if (frame_end) begin
				ones[ch] <= 8'h00;
			end else if (mod_tick) begin
				ones[ch] <= ones[ch] + {7'h00, mod_bit_i[ch]};
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			word <= '0;
		end else if (frame_end && !cfg_change) begin
			for (int ch = 0; ch < `NUM_CHANNELS; ch++) begin
				word.code[ch] <= clip_code(ones[ch] + {7'h00, mod_bit_i[ch]}, cfg);
			end
		end
	end

	// Settling counts whole output periods; words finished meanwhile are not buffered.
	always_ff @(posedge clk_sys_i) begin
		if (srst_i || cfg_change) begin
			state      <= ST_SETTLING;
			settle_cnt <= 7'h00;
		end else begin
			unique case (state)
				ST_SETTLING: begin
					if (frame_end) begin
						if (settle_cnt == cfg.settle - 7'd1) begin
							state <= ST_RUNNING;
						end
						settle_cnt <= settle_cnt + 7'd1;
					end
				end
				ST_RUNNING: begin
					settle_cnt <= settle_cnt;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i || cfg_change) begin
			word_valid <= 1'b0;
		end else begin
			word_valid <= frame_end && (state == ST_RUNNING);
		end
	end

	assign data_ready_indication_o = (state == ST_SETTLING);

	// The converter cannot pause, so a full buffer costs the word and raises a pulse.
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			overrun_o <= 1'b0;
		end else begin
			overrun_o <= word_valid && !fifo_ready;
		end
	end

	sample_fifo #(
		.WIDTH ($bits(sample_word_type)),
		.DEPTH (`FIFO_DEPTH)
	) u_fifo (
		.clk_sys_i   (clk_sys_i),
		.srst_i      (srst_i),
		.in_valid_i  (word_valid),
		.in_ready_o  (fifo_ready),
		.in_data_i   (word),
		.out_valid_o (sample_valid_o),
		.out_ready_i (sample_ready_i),
		.out_data_o  (sample_data_o)
	);

endmodule // adc_rate_filter_and_code_control

/* tb/adc_rate_asserts.sv */
// Concurrent checks on the ports of the rate and code control.
`timescale 1ns/1ps
`include "adc_rate_consts.svh"
module adc_rate_asserts
	import adc_rate_pkg::*;
(
	input wire logic                     clk_sys_i,
	input wire logic                     srst_i,
	input wire logic [1:0]               mode_sel_i,
	input wire logic                     clock_ratio_select_i,
	input wire logic [`NUM_CHANNELS-1:0] mod_bit_i,
	input wire logic                     modulator_rate_o,
	input wire logic                     data_ready_indication_o,
	input wire logic                     overrun_o,
	input wire logic                     sample_valid_o,
	input wire logic                     sample_ready_i,
	input wire sample_word_type          sample_data_o
);
	logic [2:0] cfg;
	assign cfg = {mode_sel_i, clock_ratio_select_i};
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (srst_i);
	chk_tick_gap: assert property (modulator_rate_o |=> !modulator_rate_o [*3])
		else $error("modulator ticks closer than four clocks");
	chk_hs_period: assert property ((cfg == 3'b000) [*3] ##1 (cfg == 3'b000 && modulator_rate_o) ##1
		(cfg == 3'b000) [*3] |=> modulator_rate_o) else $error("high speed tick not every 4");
	chk_hr_period: assert property ((cfg == 3'b011) [*3] ##1 (cfg == 3'b011 && modulator_rate_o) ##1
		(cfg == 3'b011) [*3] |=> modulator_rate_o) else $error("high res tick not every 4");
	chk_lp_period: assert property ((cfg == 3'b101) [*3] ##1 (cfg == 3'b101 && modulator_rate_o) ##1
		(cfg == 3'b101) [*7] |=> modulator_rate_o) else $error("low power tick not every 8");
	chk_ls_period: assert property ((cfg == 3'b110) [*3] ##1 (cfg == 3'b110 && modulator_rate_o) ##1
		(cfg == 3'b110) [*7] |=> modulator_rate_o) else $error("low speed tick not every 8");
	chk_change_busy: assert property ($changed(cfg) |-> ##[1:2] data_ready_indication_o)
		else $error("pin change did not raise the indication");
	chk_word_hold: assert property (sample_valid_o && !sample_ready_i |=>
		sample_valid_o && $stable(sample_data_o)) else $error("word changed while stalled");
	chk_overrun_full: assert property (overrun_o |-> sample_valid_o ##1 !overrun_o)
		else $error("overrun without a full buffer");
	cover property (overrun_o);
	cover property ($fell(data_ready_indication_o));
	cover property (sample_valid_o && sample_ready_i);
endmodule // adc_rate_asserts

bind adc_rate_filter_and_code_control adc_rate_asserts chk (.clk_sys_i(clk_sys_i),
	.srst_i(srst_i), .mode_sel_i(mode_sel_i), .clock_ratio_select_i(clock_ratio_select_i),
	.mod_bit_i(mod_bit_i), .modulator_rate_o(modulator_rate_o),
	.data_ready_indication_o(data_ready_indication_o), .overrun_o(overrun_o),
	.sample_valid_o(sample_valid_o), .sample_ready_i(sample_ready_i),
	.sample_data_o(sample_data_o));

/* tb/host_model.sv */
// Host side model that collects finished sample words and can stall.
`timescale 1ns/1ps
module host_model
	import adc_rate_pkg::*;
(
	input  wire logic            clk_sys_i,
	input  wire logic            stall_i,
	input  wire logic            sample_valid_i,
	input  wire sample_word_type sample_data_i,
	output logic                 sample_ready_o,
	output logic                 got_o,
	output sample_word_type      word_o
);
	assign sample_ready_o = !stall_i;
	always_ff @(posedge clk_sys_i) begin
		got_o <= sample_valid_i && sample_ready_o;
		if (sample_valid_i && sample_ready_o) begin
			word_o <= sample_data_i;
		end
	end
endmodule // host_model

/* tb/adc_rate_filter_and_code_control_tb_top.sv */
// Testbench for the rate and code control with its host model.
`timescale 1ns/1ps
module adc_rate_filter_and_code_control_tb_top;
	import adc_rate_pkg::*;
	logic clk_sys_i = 0, srst_i = 1, ratio = 0, stall = 0;
	logic [1:0] mode = 0;
	logic [3:0] bits = 0;
	logic tick, busy, ovr, vld, rdy, got;
	sample_word_type data, word;
	int fail_count = 0, checks_done = 0, n;
	// The block counts edges only, so this period stands for a host clock kept within its limit.
	initial begin
		forever #5 clk_sys_i = ~clk_sys_i;
	end
	adc_rate_filter_and_code_control uut (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
		.mode_sel_i(mode), .clock_ratio_select_i(ratio), .mod_bit_i(bits),
		.modulator_rate_o(tick), .data_ready_indication_o(busy), .overrun_o(ovr),
		.sample_valid_o(vld), .sample_ready_i(rdy), .sample_data_o(data));
	host_model host (.clk_sys_i(clk_sys_i), .stall_i(stall), .sample_valid_i(vld),
		.sample_data_i(data), .sample_ready_o(rdy), .got_o(got), .word_o(word));
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [23:0] got_v, input logic [23:0] exp_v);
		checks_done++;
		if (got_v !== exp_v) begin
			fail_count++;
			$display("[FAIL] t=%0h got %h exp %h", $time, got_v, exp_v);
		end
	endtask
	// A bounded wait that runs out is a mismatch and ends the run at once.
	task automatic bound(input int lim);
		if (n >= lim) begin
			chk(n, lim + 1);
			end_of_test();
		end
	endtask
	task automatic wait_tick();
		n = 0;
		do begin
			@(negedge clk_sys_i);
			n++;
		end while (!tick && n < 100);
		bound(100);
	endtask
	task automatic test_dividers();
		int exp_div [8] = '{4, 4, 4, 4, 4, 8, 8, 40};
		for (int i = 0; i < 8; i++) begin
			{mode, ratio} = i[2:0];
			repeat (3) wait_tick();
			chk(n, exp_div[i]);
		end
		$display("dividers done");
	endtask
	task automatic settle(input logic [2:0] cfg, input logic [3:0] b, input int len,
		input int periods, input logic [23:0] code);
		{mode, ratio} = cfg;
		bits = b;
		repeat (3) @(negedge clk_sys_i);
		chk(busy, 1);
		n = 0;
		do begin
			@(negedge clk_sys_i);
			n++;
		end while (busy && n < 50000);
		bound(50000);
		chk(n > periods * len - 8 && n < periods * len + 8, 1);
		n = 0;
		do begin
			@(negedge clk_sys_i);
			n++;
		end while (!got && n < 2 * len);
		bound(2 * len);
		for (int c = 0; c < 4; c++) chk(word.code[c], code);
		$display("settle done");
	endtask
	task automatic test_overrun();
		stall = 1;
		n = 0;
		do begin
			@(negedge clk_sys_i);
			n++;
		end while (!ovr && n < 5000);
		bound(5000);
		stall = 0;
		n = 0;
		repeat (40) begin
			@(negedge clk_sys_i);
			n += got;
		end
		chk(n, 16);
		$display("overrun done");
	endtask
	initial begin
		repeat (20) @(negedge clk_sys_i);
		srst_i = 0;
		test_dividers();
		settle(3'b000, 4'hF, 256, 76, 24'h7FFFFF);
		settle(3'b011, 4'hF, 512, 78, 24'h7FFFFF);
		settle(3'b100, 4'h0, 256, 76, 24'h800000);
		test_overrun();
		end_of_test();
	end
endmodule // adc_rate_filter_and_code_control_tb_top
